//--- tsq_regs.svh
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH

// register byte offsets
`define TSQ_ADDR_CTRL 8'h00
`define TSQ_ADDR_STATUS 8'h04
`define TSQ_ADDR_LAST_CW 8'h08
`define TSQ_ADDR_LAST_RES 8'h0C
`define TSQ_ADDR_DONE_CNT 8'h10
`define TSQ_ADDR_EVENTS 8'h14

// control register fields and reset value
`define TSQ_CTRL_EN_BIT 0
`define TSQ_CTRL_RESET 1'b1

// sticky event bits, write one to clear
`define TSQ_EVT_ABORT_BIT 0
`define TSQ_EVT_IGNORED_BIT 1

// control word layout, first bit shifted in is the start bit
`define TSQ_CW_BITS 5'd8
`define TSQ_CW_START_BIT 7
`define TSQ_CW_MODE_BIT 3
`define TSQ_CW_PD1_BIT 1
`define TSQ_CW_PD0_BIT 0
`define TSQ_PD_RESET 2'b00

// serial clock edge counts, counted from the start bit edge as one
`define TSQ_FALL_ALERT_REL 5'd4
`define TSQ_FALL_HOLD 5'd8
`define TSQ_FALL_MSB 5'd9
`define TSQ_START_GAP_12 5'd8
`define TSQ_START_GAP_8 5'd4
`define TSQ_CONV_LEN_12 4'd12
`define TSQ_CONV_LEN_8 4'd8
`define TSQ_CNT_MAX 5'd31

// bus responses
`define TSQ_RESP_OKAY 2'b00
`define TSQ_RESP_SLVERR 2'b10

`endif

//--- tsq_pkg.sv
package tsq_pkg;

  typedef enum logic [1:0] {
    TSQ_ST_IDLE = 2'b00,
    TSQ_ST_CMD = 2'b01,
    TSQ_ST_RUN = 2'b10
  } tsq_state_t;

endpackage

//--- tsq_axil_slave.sv
`timescale 1ns/100ps
`include "tsq_regs.svh"

module tsq_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_addr,
  output logic [31:0] reg_wr_data,
  output logic [3:0] reg_wr_strb,
  input wire logic reg_wr_err,
  output logic [7:0] reg_rd_addr,
  input wire logic [31:0] reg_rd_data,
  input wire logic reg_rd_err
);

  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // address and data are held separately so either may arrive first
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
  assign reg_wr_en = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign reg_wr_addr = awaddr_q;
  assign reg_wr_data = wdata_q;
  assign reg_wr_strb = wstrb_q;
  assign s_axi_arready = ~s_axi_rvalid;
  assign reg_rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (reg_wr_en) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (reg_wr_en) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSQ_RESP_OKAY;
    end else if (reg_wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_wr_err ? `TSQ_RESP_SLVERR : `TSQ_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TSQ_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= reg_rd_data;
      s_axi_rresp <= reg_rd_err ? `TSQ_RESP_SLVERR : `TSQ_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- tsq_touch_adc_serial_sequencer.sv
// Function
// [RULE1] control word sampled on first eight rises
// [RULE2] control register loads only after start bit
// [RULE3] result output low while word shifts in
// [RULE4] result MSB launched on ninth falling edge
// [RULE5] frame: nine zeros, twelve bits, three zeros
// [RULE6] deselect releases outputs, ignores command input
// [RULE7] deselect during conversion abandons that conversion
// [RULE8] selected device keeps hunting for start bits
// [RULE9] 12-bit: next start from eighth rise
// [RULE10] 8-bit: next start from fourth rise
// [RULE11] start bit accepted during running conversion
// [RULE12] host may overlap bytes for 16-clock cycles
// [RULE13] host may use 15 clocks per conversion
// [RULE14] mode bit set selects 8-bit conversion
// [RULE15] 8-bit conversion ends four clocks sooner
// [RULE16] enabled touch pulls open-drain alert low
// [RULE17] touch alert enabled right after reset
// [RULE18] start bit disables alert until conversion end
// [RULE19] held-low alert released at fourth fall
// [RULE20] new enable takes effect after conversion completes
// [RULE21] alert may stay enabled during power-down
// [RULE22] overlapped starts keep the alert disabled; the earlier conversion's end still re-enables it here when pd0 is low
// [RULE23] sleep policy bits: power and alert choice
// [RULE24] busy high at conversion start, low next fall
// [RULE25] result bits MSB first, change on falls
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "tsq_regs.svh"

module tsq_touch_adc_serial_sequencer #(
  parameter int RES_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cs_n,
  input wire logic conv_serial_clock,
  input wire logic cmd_in,
  output logic result_out,
  output logic result_oe,
  output logic busy_out,
  output logic busy_oe,
  input wire logic pen_touched,
  input wire logic [RES_W-1:0] sample_code,
  input wire logic touch_alert_n_i,
  output logic touch_alert_n_o,
  output logic touch_alert_n_oe
);

  generate
    if (RES_W != 12) begin : g_res_check
      $error("tsq: RES_W must be 12");
    end
  endgenerate

  function automatic logic tsq_mapped(input logic [7:0] addr);
    tsq_mapped = (addr == `TSQ_ADDR_CTRL) || (addr == `TSQ_ADDR_STATUS) ||
                 (addr == `TSQ_ADDR_LAST_CW) || (addr == `TSQ_ADDR_LAST_RES) ||
                 (addr == `TSQ_ADDR_DONE_CNT) || (addr == `TSQ_ADDR_EVENTS);
  endfunction

  logic reg_wr_en;
  logic [7:0] reg_wr_addr;
  logic [31:0] reg_wr_data;
  logic [3:0] reg_wr_strb;
  logic [7:0] reg_rd_addr;
  logic [31:0] reg_rd_data;

  tsq_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data),
    .reg_wr_strb(reg_wr_strb),
    .reg_wr_err(~tsq_mapped(reg_wr_addr)),
    .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data),
    .reg_rd_err(~tsq_mapped(reg_rd_addr))
  );

  tsq_pkg::tsq_state_t st_q;
  logic enable_q;
  logic sclk_q;
  logic [4:0] rcnt_q;
  logic [4:0] fcnt_q;
  logic [7:0] cw_q;
  logic conv_q;
  logic [3:0] ccnt_q;
  logic conv_mode_q;
  logic [RES_W-1:0] code_q;
  logic [RES_W-1:0] sreg_q;
  logic busy_q;
  logic [1:0] policy_q;
  logic alert_on_q;
  logic hold_low_q;
  logic alert_oe_q;
  logic [7:0] last_cw_q;
  logic [RES_W-1:0] last_res_q;
  logic [15:0] done_cnt_q;
  logic evt_abort_q;
  logic evt_ignored_q;

  logic sel;
  logic rise;
  logic fall;
  logic [4:0] rise_n;
  logic [4:0] fall_n;
  logic [4:0] start_thr;
  logic gap_met;
  logic start_hit;
  logic start_ignored;
  logic hold_ev;
  logic msb_ev;
  logic rel_ev;
  logic [3:0] conv_len;
  logic conv_end;
  logic frame_live;
  logic abort_ev;
  logic [RES_W-1:0] code_aligned;
  logic evt_clr_wr;

  // serial pins are synchronous to aclk, so edges come from one delayed copy
  assign sel = ~cs_n & enable_q;
  assign rise = sel & conv_serial_clock & ~sclk_q;
  assign fall = sel & ~conv_serial_clock & sclk_q;
  assign rise_n = (rcnt_q == `TSQ_CNT_MAX) ? rcnt_q : rcnt_q + 5'd1;
  assign fall_n = (fcnt_q == `TSQ_CNT_MAX) ? fcnt_q : fcnt_q + 5'd1;

  // blanking window counted from the start-bit rise of the captured word
  assign start_thr = cw_q[`TSQ_CW_MODE_BIT] ?
                     (`TSQ_CW_BITS + `TSQ_START_GAP_8) :
                     (`TSQ_CW_BITS + `TSQ_START_GAP_12); // [RULE9] [RULE10]
  assign gap_met = (st_q == tsq_pkg::TSQ_ST_RUN) && (rise_n >= start_thr);
  // start bits count even while a conversion runs, so bytes can overlap
  assign start_hit = rise & cmd_in &
                     ((st_q == tsq_pkg::TSQ_ST_IDLE) | gap_met); // [RULE2] [RULE8] [RULE11] [RULE12] [RULE13]
  assign start_ignored = rise & cmd_in & (st_q == tsq_pkg::TSQ_ST_RUN) & ~gap_met;

  assign hold_ev = fall & (st_q == tsq_pkg::TSQ_ST_RUN) & (fall_n == `TSQ_FALL_HOLD);
  assign msb_ev = fall & (st_q == tsq_pkg::TSQ_ST_RUN) & (fall_n == `TSQ_FALL_MSB);
  assign rel_ev = fall & (fall_n == `TSQ_FALL_ALERT_REL);

  assign conv_len = conv_mode_q ? `TSQ_CONV_LEN_8 : `TSQ_CONV_LEN_12; // [RULE14] [RULE15]
  assign conv_end = fall & conv_q & ((ccnt_q + 4'd1) == conv_len);
  assign frame_live = (st_q != tsq_pkg::TSQ_ST_IDLE) | conv_q;
  assign abort_ev = ~sel & frame_live;

  // 8-bit results drop the low nibble so the trailing bits shift out as zeros
  assign code_aligned = conv_mode_q ? {code_q[RES_W-1:4], 4'h0} : code_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= conv_serial_clock;
    end
  end

  // capture framing: start bit, then seven more command bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= tsq_pkg::TSQ_ST_IDLE;
      rcnt_q <= 5'd0;
      fcnt_q <= 5'd0;
      cw_q <= 8'h00;
    end else if (!sel) begin
      st_q <= tsq_pkg::TSQ_ST_IDLE; // [RULE6]
      rcnt_q <= 5'd0;
      fcnt_q <= 5'd0;
    end else if (start_hit) begin
      st_q <= tsq_pkg::TSQ_ST_CMD;
      rcnt_q <= 5'd1;
      fcnt_q <= 5'd0;
      cw_q <= 8'h01;
    end else if (rise) begin
      rcnt_q <= rise_n;
      if (st_q == tsq_pkg::TSQ_ST_CMD) begin
        cw_q <= {cw_q[6:0], cmd_in}; // [RULE1]
        if (rise_n == `TSQ_CW_BITS) begin
          st_q <= tsq_pkg::TSQ_ST_RUN;
        end
      end
    end else if (fall) begin
      fcnt_q <= fall_n;
    end
  end

  // conversion runs on its own count so an overlapped start does not cut it short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_q <= 1'b0;
      ccnt_q <= 4'd0;
      conv_mode_q <= 1'b0;
      code_q <= '0;
    end else if (!sel) begin
      conv_q <= 1'b0; // [RULE7]
      ccnt_q <= 4'd0;
    end else if (hold_ev) begin
      conv_q <= 1'b1;
      ccnt_q <= 4'd0;
      conv_mode_q <= cw_q[`TSQ_CW_MODE_BIT]; // [RULE14]
      code_q <= sample_code;
    end else if (conv_end) begin
      conv_q <= 1'b0; // [RULE15]
      ccnt_q <= 4'd0;
    end else if (fall && conv_q) begin
      ccnt_q <= ccnt_q + 4'd1;
    end
  end

  // output shifter stays zero until the ninth fall, giving the leading zeros
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sreg_q <= '0;
    end else if (!sel) begin
      sreg_q <= '0;
    end else if (msb_ev) begin
      sreg_q <= code_aligned; // [RULE4] [RULE5]
    end else if (fall) begin
      sreg_q <= {sreg_q[RES_W-2:0], 1'b0}; // [RULE25] [RULE5] [RULE3]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else if (!sel) begin
      busy_q <= 1'b0;
    end else if (hold_ev) begin
      busy_q <= 1'b1; // [RULE24]
    end else if (fall) begin
      busy_q <= 1'b0; // [RULE24]
    end
  end

  assign result_out = sreg_q[RES_W-1];
  assign result_oe = sel; // [RULE6]
  assign busy_out = busy_q;
  assign busy_oe = sel; // [RULE6]

  // sleep policy bits become active only when acquisition ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      policy_q <= `TSQ_PD_RESET; // [RULE17]
    end else if (hold_ev) begin
      policy_q <= {cw_q[`TSQ_CW_PD1_BIT], cw_q[`TSQ_CW_PD0_BIT]}; // [RULE23]
    end
  end

  // pd0 low means alert enabled, whether or not the converter sleeps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_on_q <= 1'b1; // [RULE17]
    end else if (abort_ev) begin
      alert_on_q <= ~policy_q[`TSQ_CW_PD0_BIT];
    end else if (start_hit) begin
      alert_on_q <= 1'b0; // [RULE18] [RULE22]
    end else if (conv_end) begin
      alert_on_q <= ~policy_q[`TSQ_CW_PD0_BIT]; // [RULE20] [RULE21] [RULE23]
    end
  end

  // a low alert is latched at the start bit so the pin cannot bounce mid-word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_low_q <= 1'b0;
    end else if (abort_ev) begin
      hold_low_q <= 1'b0;
    end else if (start_hit) begin
      hold_low_q <= alert_oe_q; // [RULE19]
    end else if (rel_ev) begin
      hold_low_q <= 1'b0; // [RULE19]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_oe_q <= 1'b0;
    end else if (rel_ev) begin
      alert_oe_q <= alert_on_q & pen_touched; // [RULE19]
    end else begin
      alert_oe_q <= hold_low_q | (alert_on_q & pen_touched); // [RULE16]
    end
  end

  // open drain: only ever drive low, the pull-up makes the idle high
  assign touch_alert_n_o = 1'b0; // [RULE16]
  assign touch_alert_n_oe = alert_oe_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_cw_q <= 8'h00;
      last_res_q <= '0;
      done_cnt_q <= 16'h0000;
    end else begin
      if (hold_ev) begin
        last_cw_q <= cw_q;
      end
      if (conv_end) begin
        last_res_q <= code_aligned;
        done_cnt_q <= done_cnt_q + 16'h0001;
      end
    end
  end

  assign evt_clr_wr = reg_wr_en && (reg_wr_addr == `TSQ_ADDR_EVENTS) && reg_wr_strb[0];

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_abort_q <= 1'b0;
      evt_ignored_q <= 1'b0;
    end else begin
      if (conv_q && !sel) begin
        evt_abort_q <= 1'b1;
      end else if (evt_clr_wr && reg_wr_data[`TSQ_EVT_ABORT_BIT]) begin
        evt_abort_q <= 1'b0;
      end
      if (start_ignored) begin
        evt_ignored_q <= 1'b1;
      end else if (evt_clr_wr && reg_wr_data[`TSQ_EVT_IGNORED_BIT]) begin
        evt_ignored_q <= 1'b0;
      end
    end
  end

  // disabling the port looks like a deselect to the serial logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= `TSQ_CTRL_RESET;
    end else if (reg_wr_en && (reg_wr_addr == `TSQ_ADDR_CTRL) && reg_wr_strb[0]) begin
      enable_q <= reg_wr_data[`TSQ_CTRL_EN_BIT];
    end
  end

  always_comb begin
    reg_rd_data = 32'h0000_0000;
    if (reg_rd_addr == `TSQ_ADDR_CTRL) begin
      reg_rd_data[`TSQ_CTRL_EN_BIT] = enable_q;
    end else if (reg_rd_addr == `TSQ_ADDR_STATUS) begin
      reg_rd_data[1:0] = st_q;
      reg_rd_data[2] = conv_q;
      reg_rd_data[3] = busy_q;
      reg_rd_data[4] = alert_on_q;
      reg_rd_data[6:5] = policy_q;
      reg_rd_data[7] = conv_mode_q;
      reg_rd_data[8] = conv_q | policy_q[`TSQ_CW_PD1_BIT];
      reg_rd_data[9] = touch_alert_n_i;
      reg_rd_data[10] = sel;
    end else if (reg_rd_addr == `TSQ_ADDR_LAST_CW) begin
      reg_rd_data[7:0] = last_cw_q;
    end else if (reg_rd_addr == `TSQ_ADDR_LAST_RES) begin
      reg_rd_data[RES_W-1:0] = last_res_q;
    end else if (reg_rd_addr == `TSQ_ADDR_DONE_CNT) begin
      reg_rd_data[15:0] = done_cnt_q;
    end else if (reg_rd_addr == `TSQ_ADDR_EVENTS) begin
      reg_rd_data[`TSQ_EVT_ABORT_BIT] = evt_abort_q;
      reg_rd_data[`TSQ_EVT_IGNORED_BIT] = evt_ignored_q;
    end
  end

endmodule

//--- tsq_assertions.sv
`timescale 1ns/100ps
module tsq_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic conv_serial_clock,
  input wire logic pen_touched,
  input wire logic result_out,
  input wire logic result_oe,
  input wire logic busy_out,
  input wire logic busy_oe,
  input wire logic touch_alert_n_o,
  input wire logic touch_alert_n_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_oe_deselect: assert property (cs_n |-> !result_oe)
    else $error("result line driven while deselected");
  a_oe_pair: assert property (busy_oe == result_oe)
    else $error("busy and result enables differ");
  // window allows for input sampling delay in front of the fall detector
  a_busy_short: assert property (busy_out && $fell(conv_serial_clock) |-> ##[1:3] !busy_out)
    else $error("busy outlived the next serial fall");
  a_busy_selected: assert property (cs_n && $past(cs_n) |-> !busy_out)
    else $error("busy high after deselect");
  a_result_on_fall: assert property (
    !cs_n && !$past(cs_n) && $changed(result_out) |-> !conv_serial_clock)
    else $error("result bit changed while serial clock high");
  a_alert_reset: assert property ($rose(aresetn) ##0 pen_touched [*3] |-> touch_alert_n_oe)
    else $error("touch alert not enabled after reset");
  a_alert_pull: assert property (touch_alert_n_oe |-> !touch_alert_n_o)
    else $error("alert pin driven high");
  a_alert_cause: assert property ($rose(touch_alert_n_oe) |-> $past(pen_touched))
    else $error("alert asserted without a touch");
endmodule

bind tsq_touch_adc_serial_sequencer tsq_assertions i_tsq_assertions (
  .aclk(aclk),
  .aresetn(aresetn),
  .cs_n(cs_n),
  .conv_serial_clock(conv_serial_clock),
  .pen_touched(pen_touched),
  .result_out(result_out),
  .result_oe(result_oe),
  .busy_out(busy_out),
  .busy_oe(busy_oe),
  .touch_alert_n_o(touch_alert_n_o),
  .touch_alert_n_oe(touch_alert_n_oe)
);

//--- tsq_host_model.sv
`timescale 1ns/100ps
module tsq_host_model (
  input wire logic aclk,
  input wire logic result_out,
  input wire logic result_oe,
  input wire logic touch_alert_n_oe,
  input wire logic busy_out,
  output logic cs_n,
  output logic conv_serial_clock,
  output logic cmd_in
);
  // released line shows the inverse of its last level, never a stale bit
  logic last_q = 1'h0;
  logic [47:0] bz;
  wire dout_w = result_oe ? result_out : ~last_q;
  // only a driven level is remembered, so a released line stays steady
  always @(posedge aclk) if (result_oe) last_q <= result_out;

  initial begin
    cs_n = 1'h1;
    conv_serial_clock = 1'h0;
    cmd_in = 1'h0;
  end

  task automatic sel(input logic v);
    @(posedge aclk);
    cs_n <= v;
  endtask

  // three aclk per level, so a bit is settled before the host samples it
  task automatic run(input logic [47:0] cmd, input int n, output logic [47:0] got,
                     output logic [47:0] al);
    got = '0;
    al = '0;
    bz = '0;
    for (int r = 1; r <= n; r++) begin
      @(posedge aclk);
      conv_serial_clock <= 1'h0;
      cmd_in <= cmd[48 - r];
      repeat (3) @(posedge aclk);
      got[48 - r] = dout_w;
      al[48 - r] = touch_alert_n_oe;
      bz[48 - r] = busy_out;
      conv_serial_clock <= 1'h1;
      repeat (2) @(posedge aclk);
    end
    @(posedge aclk);
    conv_serial_clock <= 1'h0;
  endtask
endmodule

//--- tsq_touch_adc_serial_sequencer_test.sv
`timescale 1ns/100ps
`include "tsq_regs.svh"
module tsq_touch_adc_serial_sequencer_test;
  logic aclk = 1'h0, aresetn = 1'h0, pen = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, busy_out, busy_oe;
  logic [1:0] bresp, rresp;
  logic cs_n, sclk, cmd_in, result_out, result_oe, alert_o, alert_oe;
  logic [11:0] code = 12'h0;
  wire alert_pin = alert_oe ? alert_o : 1'h1;
  int fails = 0, n_checks = 0;
  logic [31:0] seed = 32'h1;

  initial forever #5 aclk = ~aclk;

  tsq_touch_adc_serial_sequencer i_tsq_touch_adc_serial_sequencer (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cs_n(cs_n),
    .conv_serial_clock(sclk), .cmd_in(cmd_in), .result_out(result_out),
    .result_oe(result_oe), .busy_out(busy_out), .busy_oe(busy_oe), .pen_touched(pen),
    .sample_code(code), .touch_alert_n_i(alert_pin), .touch_alert_n_o(alert_o),
    .touch_alert_n_oe(alert_oe));

  tsq_host_model i_tsq_host_model (.aclk(aclk), .result_out(result_out),
    .result_oe(result_oe), .touch_alert_n_oe(alert_oe), .busy_out(busy_out), .cs_n(cs_n),
    .conv_serial_clock(sclk), .cmd_in(cmd_in));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [47:0] mk(int s, logic [6:0] w);
    return {40'h0, 1'h1, w} << (41 - s);
  endfunction

  function automatic logic [47:0] exp_out(int s1, logic m0, logic m1, logic [11:0] c);
    logic [47:0] v;
    int f;
    v = '0;
    for (int r = 1; r <= 48; r++) begin
      f = r - 9;
      if (f >= 1 && f <= (m0 ? 8 : 12)) v[48 - r] = c[12 - f];
      f = r - s1 - 8;
      if (s1 > 0 && f >= 1 && f <= (m1 ? 8 : 12)) v[48 - r] = c[12 - f];
    end
    return v;
  endfunction

  function automatic logic [47:0] exp_al(logic on, logic m, logic pd0);
    logic [47:0] v;
    v = '0;
    for (int r = 1; r <= 24; r++) begin
      if (r <= 4) v[48 - r] = on;
      else if (r > (m ? 16 : 20)) v[48 - r] = ~pd0;
    end
    return v;
  endfunction

  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tmo(input int t);
    if (t >= 60) begin
      fails++;
      $display("mismatch at %0t: bus answer timed out", $time);
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int t;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= v;
    wstrb <= 4'hF;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
    tmo(t);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'h0;
    tmo(t);
  endtask

  initial begin
    logic [47:0] got, al, cmd;
    logic [31:0] d, c0, e;
    logic [1:0] r;
    logic on;
    int s1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (5) @(posedge aclk);
    chk(alert_oe, 1'h1);
    chk(alert_pin, 1'h0);
    rd(`TSQ_ADDR_CTRL, d, r);
    chk({r, d[0]}, 3'h1);
    rd(8'h18, d, r);
    chk(r, `TSQ_RESP_SLVERR);
    wr(8'h18, 32'h0, r);
    chk(r, `TSQ_RESP_SLVERR);
    wr(`TSQ_ADDR_CTRL, 32'h0, r);
    i_tsq_host_model.sel(1'h0);
    @(posedge aclk);
    chk(result_oe, 1'h0);
    wr(`TSQ_ADDR_CTRL, 32'h1, r);
    @(posedge aclk);
    chk({busy_oe, result_oe}, 2'h3);
    rd(`TSQ_ADDR_DONE_CNT, c0, r);
    on = 1'h1;
    // every sleep policy in both resolutions, select held low throughout
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      code <= d[11:0];
      i_tsq_host_model.run(mk(1, {d[14:12], i[2], 1'h0, i[1:0]}), 24, got, al);
      chk(got, exp_out(0, i[2], 1'h0, d[11:0]));
      chk(al, exp_al(on, i[2], i[0]));
      chk(i_tsq_host_model.bz, 48'h1 << 39);
      rd(`TSQ_ADDR_LAST_CW, e, r);
      chk(e[7:0], {1'h1, d[14:12], i[2], 1'h0, i[1:0]});
      rd(`TSQ_ADDR_LAST_RES, e, r);
      chk(e[11:0], i[2] ? {d[11:4], 4'h0} : d[11:0]);
      on = ~i[0];
    end
    rd(`TSQ_ADDR_DONE_CNT, d, r);
    chk(d[15:0], c0[15:0] + 16'h8);
    pen <= 1'h0;
    for (int m = 0; m < 2; m++) begin
      s1 = m ? 12 : 16;
      d = rnd();
      code <= d[11:0];
      // early start one rise inside blanking, then the earliest legal one
      cmd = mk(1, {d[14:12], m[0], 3'h2}) | mk(s1, {d[17:15], 4'h2}) | (48'h1 << (49 - s1));
      rd(`TSQ_ADDR_DONE_CNT, c0, r);
      i_tsq_host_model.run(cmd, s1 + 23, got, al);
      chk(got, exp_out(s1, m[0], 1'h0, d[11:0]));
      rd(`TSQ_ADDR_EVENTS, e, r);
      chk(e[1], 1'h1);
      wr(`TSQ_ADDR_EVENTS, 32'h3, r);
      rd(`TSQ_ADDR_EVENTS, e, r);
      chk(e[1:0], 2'h0);
      rd(`TSQ_ADDR_DONE_CNT, d, r);
      chk(d[15:0], c0[15:0] + 16'h2);
    end
    rd(`TSQ_ADDR_DONE_CNT, c0, r);
    i_tsq_host_model.run(mk(1, 7'h0A), 14, got, al);
    i_tsq_host_model.sel(1'h1);
    repeat (2) @(posedge aclk);
    chk({busy_oe, result_oe}, 2'h0);
    i_tsq_host_model.run(mk(1, 7'h0A), 24, got, al);
    i_tsq_host_model.sel(1'h0);
    i_tsq_host_model.run(48'h0, 24, got, al);
    chk(got, 48'h0);
    rd(`TSQ_ADDR_EVENTS, e, r);
    chk(e[0], 1'h1);
    rd(`TSQ_ADDR_DONE_CNT, d, r);
    chk(d[15:0], c0[15:0]);
    end_sim();
  end
endmodule
